// File: src/dpsem_host_pkg.sv
// Package for the dual-port semaphore and mailbox host controller.
// Assumes a 100 MHz ref_clk; all pin timing is expressed in clock cycles.
`default_nettype none
package dpsem_host_pkg;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // Pin widths of one port of the dual-port device
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int SEM_IDX_W = 3;
  // Mailbox addresses: top word is the right mailbox, next the left one
  localparam logic [16:0] RIGHT_MBOX_ADDR = 17'h1ffff;
  localparam logic [16:0] LEFT_MBOX_ADDR = 17'h1fffe;
  // Timing figures in ns
  localparam int SEM_RELEASE_GAP_TIME_NS = 15;
  localparam int SEM_WRITE_TO_READ_DELAY_NS = 10;
  localparam int ACCESS_TIME_NS = 25;
  localparam int WRITE_PULSE_TIME_NS = 20;
  // Least times rounded up to cycles
  localparam int GAP_CYC = (SEM_RELEASE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (ACCESS_TIME_NS + SEM_WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int WR_CYC = (WRITE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the phase counter
  localparam int CNT_W = 4;
  // Software register offsets (word index on the command port)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // Command codes written to REG_CMD
  localparam logic [2:0] CMD_MEM_WRITE = 3'h1;
  localparam logic [2:0] CMD_MEM_READ = 3'h2;
  localparam logic [2:0] CMD_SEM_CLAIM = 3'h3;
  localparam logic [2:0] CMD_SEM_RELEASE = 3'h4;
  localparam logic [2:0] CMD_SEM_READ = 3'h5;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_OWNED = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_POLLING = 3;
  // Reset values
  localparam logic [16:0] ADDR_RST = 17'h00000;
  localparam logic [8:0] DATA_RST = 9'h000;
endpackage : dpsem_host_pkg
`default_nettype wire

// File: src/dpsem_pin_cycle.sv
// One asynchronous pin cycle on a port of the dual-port device.
// Assumes the device answers within the access time held in the package.
`default_nettype none
module dpsem_pin_cycle (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request from the sequencer
  input wire logic start,
  input wire logic is_write,
  input wire logic is_sem,
  input wire logic [16:0] addr,
  input wire logic [8:0] wdata,
  // Completion
  output logic done,
  output logic [8:0] rdata,
  // Device pins
  output logic chip_select_n,
  output logic semaphore_select_n,
  output logic read_not_write,
  output logic output_enable_n,
  output logic [16:0] addr_pin,
  output logic [8:0] data_out,
  output logic data_oe,
  input wire logic [8:0] data_in
);
  // Cycle phases
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_GAP} phase_type;
  phase_type phase_r;
  logic [dpsem_host_pkg::CNT_W-1:0] cnt_r;
  logic wr_r;
  logic sem_r;
  logic [8:0] din_s1_r;
  logic [8:0] din_s2_r;
  // Length of the active phase
  wire logic [dpsem_host_pkg::CNT_W-1:0] active_len =
    wr_r ? dpsem_host_pkg::CNT_W'(dpsem_host_pkg::WR_CYC)
         : dpsem_host_pkg::CNT_W'(dpsem_host_pkg::ACC_CYC + 2);
  wire logic cnt_last = (cnt_r == '0);

  // Data pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_r <= dpsem_host_pkg::DATA_RST;
      din_s2_r <= dpsem_host_pkg::DATA_RST;
    end else begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  // Phase sequencer; strobes go high for the gap after every cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      sem_r <= 1'b0;
      addr_pin <= dpsem_host_pkg::ADDR_RST;
      data_out <= dpsem_host_pkg::DATA_RST;
      rdata <= dpsem_host_pkg::DATA_RST;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_r)
        PH_IDLE: begin
          if (start) begin
            wr_r <= is_write;
            sem_r <= is_sem;
            addr_pin <= addr;
            data_out <= wdata;
            cnt_r <= '0;
            phase_r <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          cnt_r <= active_len;
          phase_r <= PH_ACTIVE;
        end
        PH_ACTIVE: begin
          if (cnt_last) begin
            if (!wr_r) rdata <= din_s2_r;
            cnt_r <= dpsem_host_pkg::CNT_W'(dpsem_host_pkg::GAP_CYC);
            phase_r <= PH_GAP;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        PH_GAP: begin
          if (cnt_last) begin
            done <= 1'b1;
            phase_r <= PH_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  // Pin decode; chip and semaphore selects are never low together
  wire logic active = (phase_r == PH_ACTIVE);
  assign chip_select_n = !(active && !sem_r);
  assign semaphore_select_n = !(active && sem_r);
  assign read_not_write = !(active && wr_r);
  assign output_enable_n = !(active && !wr_r);
  assign data_oe = active && wr_r;

  // Selects stay exclusive
  a_sel_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!chip_select_n && !semaphore_select_n)) else $error("both selects low");
endmodule : dpsem_pin_cycle
`default_nettype wire

// File: src/dpsem_host_ctrl.sv
// Host controller for one port of a dual-port RAM with semaphores and mailbox.
// Assumes software on a plain strobe port and the device pins on the other side.
`default_nettype none
module dpsem_host_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Which port this host drives: high for the left port
  input wire logic is_left_port,
  // Device pins
  output logic chip_select_n,
  output logic semaphore_select_n,
  output logic read_not_write,
  output logic output_enable_n,
  output logic [16:0] addr_pin,
  output logic [8:0] data_out,
  output logic data_oe,
  input wire logic [8:0] data_in,
  input wire logic mailbox_irq_n
);
  // Sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CLAIM_WR, ST_CLAIM_RD, ST_SINGLE} seq_type;
  seq_type state_r;
  logic [16:0] addr_r;
  logic [8:0] wdata_r;
  logic [8:0] rdata_r;
  logic owned_r;
  logic polling_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic start_r;
  logic is_write_r;
  logic is_sem_r;
  logic [16:0] cyc_addr_r;
  logic [8:0] cyc_wdata_r;
  logic [8:0] cyc_rdata;
  logic cyc_done;

  // Register decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction
  wire logic busy = (state_r != ST_IDLE);
  wire logic cmd_wr = reg_write && hit(reg_addr, dpsem_host_pkg::REG_CMD) && !busy;
  wire logic [2:0] cmd_code = reg_wdata[2:0];
  wire logic [31:0] status_word = {28'h0000000, polling_r, !irq_s2_r, owned_r, busy};
  // Semaphore address keeps only the latch index
  wire logic [16:0] sem_addr = {14'h0000, addr_r[2:0]};
  // Own mailbox is the second-highest word on the left, highest on the right
  wire logic [16:0] own_mbox = is_left_port ? dpsem_host_pkg::LEFT_MBOX_ADDR
                                            : dpsem_host_pkg::RIGHT_MBOX_ADDR;
  wire logic [16:0] peer_mbox = is_left_port ? dpsem_host_pkg::RIGHT_MBOX_ADDR
                                             : dpsem_host_pkg::LEFT_MBOX_ADDR;
  wire logic claim_won = !cyc_rdata[0];

  // Interrupt pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
    end else begin
      irq_s1_r <= mailbox_irq_n;
      irq_s2_r <= irq_s1_r;
    end
  end

  // Software writable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= dpsem_host_pkg::ADDR_RST;
      wdata_r <= dpsem_host_pkg::DATA_RST;
    end else begin
      if (reg_write && hit(reg_addr, dpsem_host_pkg::REG_ADDR)) addr_r <= reg_wdata[16:0];
      if (reg_write && hit(reg_addr, dpsem_host_pkg::REG_WDATA)) wdata_r <= reg_wdata[8:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        dpsem_host_pkg::REG_ADDR: reg_rdata <= {15'h0000, addr_r};
        dpsem_host_pkg::REG_WDATA: reg_rdata <= {23'h000000, wdata_r};
        dpsem_host_pkg::REG_STATUS: reg_rdata <= status_word;
        dpsem_host_pkg::REG_RDATA: reg_rdata <= {23'h000000, rdata_r};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Command sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      is_write_r <= 1'b0;
      is_sem_r <= 1'b0;
      cyc_addr_r <= dpsem_host_pkg::ADDR_RST;
      cyc_wdata_r <= dpsem_host_pkg::DATA_RST;
      rdata_r <= dpsem_host_pkg::DATA_RST;
      owned_r <= 1'b0;
      polling_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr) begin
            start_r <= 1'b1;
            case (cmd_code)
              dpsem_host_pkg::CMD_MEM_WRITE: begin
                // Mailbox writes go to addr_r; the peer mailbox raises its interrupt
                is_write_r <= 1'b1;
                is_sem_r <= 1'b0;
                cyc_addr_r <= addr_r;
                cyc_wdata_r <= wdata_r;
                state_r <= ST_SINGLE;
              end
              dpsem_host_pkg::CMD_MEM_READ: begin
                is_write_r <= 1'b0;
                is_sem_r <= 1'b0;
                cyc_addr_r <= addr_r;
                state_r <= ST_SINGLE;
              end
              dpsem_host_pkg::CMD_SEM_CLAIM: begin
                // Request by writing zero on data bit zero
                is_write_r <= 1'b1;
                is_sem_r <= 1'b1;
                cyc_addr_r <= sem_addr;
                cyc_wdata_r <= 9'h000;
                polling_r <= 1'b1;
                state_r <= ST_CLAIM_WR;
              end
              dpsem_host_pkg::CMD_SEM_RELEASE: begin
                is_write_r <= 1'b1;
                is_sem_r <= 1'b1;
                cyc_addr_r <= sem_addr;
                cyc_wdata_r <= 9'h001;
                owned_r <= 1'b0;
                state_r <= ST_SINGLE;
              end
              dpsem_host_pkg::CMD_SEM_READ: begin
                is_write_r <= 1'b0;
                is_sem_r <= 1'b1;
                cyc_addr_r <= sem_addr;
                state_r <= ST_SINGLE;
              end
              default: begin
                start_r <= 1'b0;
              end
            endcase
          end
        end
        ST_CLAIM_WR: begin
          // Pin cycle ends with the release gap before the verifying read
          if (cyc_done) begin
            start_r <= 1'b1;
            is_write_r <= 1'b0;
            state_r <= ST_CLAIM_RD;
          end
        end
        ST_CLAIM_RD: begin
          if (cyc_done) begin
            rdata_r <= cyc_rdata;
            if (claim_won) begin
              owned_r <= 1'b1;
              polling_r <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              start_r <= 1'b1;
            end
          end
        end
        ST_SINGLE: begin
          if (cyc_done) begin
            if (!is_write_r) rdata_r <= cyc_rdata;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // One pin cycle at a time
  dpsem_pin_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(start_r),
    .is_write(is_write_r),
    .is_sem(is_sem_r),
    .addr(cyc_addr_r),
    .wdata(cyc_wdata_r),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .chip_select_n(chip_select_n),
    .semaphore_select_n(semaphore_select_n),
    .read_not_write(read_not_write),
    .output_enable_n(output_enable_n),
    .addr_pin(addr_pin),
    .data_out(data_out),
    .data_oe(data_oe),
    .data_in(data_in)
  );

  // Never both selects low together
  a_selects_apart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!chip_select_n && !semaphore_select_n)) else $error("selects both low");
  // Verifying read follows a gap with the semaphore select high
  a_gap_before_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CLAIM_WR && $rose(semaphore_select_n)) |-> semaphore_select_n[*2])
    else $error("no release gap");
  // Semaphore write drives only bit zero
  a_sem_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!semaphore_select_n && data_oe) |-> (data_out[8:1] == 8'h00)) else $error("high bits");
  // Semaphore address holds only the latch index
  a_sem_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !semaphore_select_n |-> (addr_pin[16:3] == 14'h0000)) else $error("sem addr");
  // Claim read of one repeats the poll
  a_poll_again: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CLAIM_RD && cyc_done && cyc_rdata[0]) |=> start_r) else $error("no poll");
  // Claim read of zero sets ownership
  a_own_on_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CLAIM_RD && cyc_done && !cyc_rdata[0]) |=> owned_r) else $error("no own");
  // Semaphore write keeps output enable high
  a_sem_wr_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!semaphore_select_n && !read_not_write) |-> (output_enable_n && chip_select_n))
    else $error("sem write pins");
  // Claim writes zero
  a_claim_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CLAIM_WR && data_oe) |-> !data_out[0]) else $error("claim not zero");
  // Mailbox addresses are complementary
  a_mbox_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    own_mbox != peer_mbox) else $error("mailbox clash");
endmodule : dpsem_host_ctrl
`default_nettype wire

// File: dv/dpsem_dev_model.sv
// Behavioural dual-port device: eight semaphore latches and two mailbox flags.
// Assumes hosts hold strobes over 1 ns; bit 0 is the left port, bit 1 the right.
`default_nettype none
module dpsem_dev_model (
  // Port pins
  input wire logic [1:0] cs_n,
  input wire logic [1:0] sem_n,
  input wire logic [1:0] rnw,
  input wire logic [1:0] oe_n,
  input wire logic [1:0][16:0] addr,
  input wire logic [1:0][8:0] din,
  input wire logic [1:0] den,
  // Data and mailbox flags towards the hosts
  output wire logic [1:0][8:0] q,
  output logic [1:0] irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] own [8]; // Owner: 0 free, 1 left, 2 right
  logic [7:0] pend [2]; // Waiting claim per port and latch
  logic [8:0] mem [logic [16:0]]; // Sparse word store
  logic [1:0][8:0] rq; // Output holding registers
  // Access decode; both selects low does nothing
  wire logic [1:0] semw = ~sem_n & cs_n & ~rnw;
  wire logic [1:0] memw = sem_n & ~cs_n & ~rnw;
  wire logic [1:0] semr = ~sem_n & cs_n & rnw & ~oe_n; // Flag read
  wire logic [1:0] memr = sem_n & ~cs_n & rnw & ~oe_n;
  // Released lines show the inverse of the last word
  assign q[0] = (semr[0] | memr[0]) ? rq[0] : ~rq[0];
  assign q[1] = (semr[1] | memr[1]) ? rq[1] : ~rq[1];
  // All latches free at start
  initial begin
    foreach (own[i]) own[i] = 2'd0;
    pend[0] = 8'h00;
    pend[1] = 8'h00;
    rq = '0;
    irq_n = 2'b11;
  end
  // One access of port p
  task automatic act(input int p);
    logic [2:0] i;
    logic v;
    int o;
    i = addr[p][2:0]; // Low bits pick one of eight latches
    v = den[p] ? din[p][0] : ~rq[p][0]; // Only bit zero counts
    o = 1 - p;
    if (semw[p] && !v) begin
      // First claim wins, later ones wait
      if (own[i] == 2'd0) own[i] = 2'(p + 1);
      else if (own[i] != 2'(p + 1)) pend[p][i] = 1'b1;
    end else if (semw[p]) begin
      // Release hands over to a waiting claim
      if (own[i] == 2'(p + 1)) begin
        own[i] = pend[o][i] ? 2'(o + 1) : 2'd0;
        pend[o][i] = 1'b0;
      end else pend[p][i] = 1'b0;
    end
    // Write to the peer mailbox raises the peer flag
    if (memw[p]) begin
      mem[addr[p]] = den[p] ? din[p] : ~rq[p];
      if (addr[p] == (p ? dpsem_host_pkg::LEFT_MBOX_ADDR : dpsem_host_pkg::RIGHT_MBOX_ADDR))
        irq_n[o] = 1'b0;
    end
    if (semr[p]) rq[p] = {9{own[i] != 2'(p + 1)}}; // Value on all lines
    // Only the own mailbox read clears the own flag
    if (memr[p]) begin
      rq[p] = mem.exists(addr[p]) ? mem[addr[p]] : 9'h000;
      if (addr[p] == (p ? dpsem_host_pkg::RIGHT_MBOX_ADDR : dpsem_host_pkg::LEFT_MBOX_ADDR))
        irq_n[p] = 1'b1;
    end
  endtask
  // Accesses act 1 ns after their strobe opens
  always @(posedge semw[0] or posedge memw[0] or posedge semr[0] or posedge memr[0]) #1 act(0);
  always @(posedge semw[1] or posedge memw[1] or posedge semr[1] or posedge memr[1]) #1 act(1);
endmodule // dpsem_dev_model
`default_nettype wire

// File: dv/tb.sv
// Bench: host controller on the left port, bench drives the right port.
// Assumes the behavioural device model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_n, reg_write, reg_read, r_cs, r_sem, r_rnw, r_oe, r_den;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, q, st;
  logic [16:0] r_addr;
  logic [8:0] r_d, rv;
  wire logic [31:0] reg_rdata;
  wire logic h_cs, h_sem, h_rnw, h_oe, data_oe;
  wire logic [16:0] h_addr;
  wire logic [8:0] data_out;
  wire logic [1:0][8:0] dq;
  wire logic [1:0] irq_n;
  int n_errors = 0;
  int n_checks = 0;
  // Row: command, address, data, read data, right view, owned, right semaphore access
  typedef struct packed {
    logic [2:0] c;
    logic [16:0] a;
    logic [8:0] d, rd, rq;
    logic own, s;
  } row_type;
  row_type rows [8] = '{
    '{dpsem_host_pkg::CMD_SEM_CLAIM, 17'h1fff5, 9'h000, 9'h000, 9'h1ff, 1'b1, 1'b1},
    '{dpsem_host_pkg::CMD_SEM_READ, 17'h00005, 9'h000, 9'h000, 9'h1ff, 1'b1, 1'b1},
    '{dpsem_host_pkg::CMD_SEM_RELEASE, 17'h0aaa5, 9'h001, 9'h000, 9'h1ff, 1'b0, 1'b1},
    '{dpsem_host_pkg::CMD_SEM_READ, 17'h00005, 9'h000, 9'h1ff, 9'h1ff, 1'b0, 1'b1},
    '{dpsem_host_pkg::CMD_SEM_CLAIM, 17'h1fff8, 9'h000, 9'h000, 9'h1ff, 1'b1, 1'b1},
    '{dpsem_host_pkg::CMD_SEM_RELEASE, 17'h00000, 9'h001, 9'h000, 9'h1ff, 1'b0, 1'b1},
    '{dpsem_host_pkg::CMD_MEM_WRITE, 17'h00123, 9'h15a, 9'h000, 9'h15a, 1'b0, 1'b0},
    '{dpsem_host_pkg::CMD_MEM_READ, 17'h00123, 9'h000, 9'h15a, 9'h15a, 1'b0, 1'b0}};
  dpsem_host_ctrl dpsem_host_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .is_left_port(1'b1), .chip_select_n(h_cs), .semaphore_select_n(h_sem),
    .read_not_write(h_rnw), .output_enable_n(h_oe), .addr_pin(h_addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(dq[0]), .mailbox_irq_n(irq_n[0]));
  dpsem_dev_model dpsem_dev_model_i (.cs_n({r_cs, h_cs}), .sem_n({r_sem, h_sem}),
    .rnw({r_rnw, h_rnw}), .oe_n({r_oe, h_oe}), .addr({r_addr, h_addr}),
    .din({r_d, data_out}), .den({r_den, data_oe}), .q(dq), .irq_n(irq_n));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Register write and read
  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rr(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  // Start one command
  task automatic go(input logic [2:0] c, input logic [16:0] a, input logic [8:0] d);
    rw(dpsem_host_pkg::REG_ADDR, 32'(a));
    rw(dpsem_host_pkg::REG_WDATA, 32'(d));
    rw(dpsem_host_pkg::REG_CMD, 32'(c));
  endtask
  // Poll status until idle, bounded
  task automatic idle();
    int n;
    n = 0;
    do begin
      rr(dpsem_host_pkg::REG_STATUS);
      n++;
    end while (q[dpsem_host_pkg::ST_BUSY] !== 1'b0 && n < 300);
    st = q;
  endtask
  // Right-port cycle, chip select high in semaphore access, gap after
  task automatic racc(input logic s, input logic w, input logic [16:0] a, input logic [8:0] d);
    @(posedge ref_clk);
    r_addr <= a;
    r_d <= d;
    r_den <= w;
    @(posedge ref_clk);
    r_cs <= s;
    r_sem <= !s;
    r_rnw <= !w;
    r_oe <= w;
    repeat (4) @(posedge ref_clk);
    rv = dq[1];
    {r_cs, r_sem, r_rnw, r_oe, r_den} <= 5'b11110;
    @(posedge ref_clk);
  endtask
  // Watchdog
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {r_cs, r_sem, r_rnw, r_oe, r_den, r_addr, r_d} = {5'b11110, 26'h0};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("idle pins", 32'({h_cs, h_sem, h_rnw, h_oe, data_oe}), 32'h1e);
    rr(4'hf);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      racc(1'b1, 1'b0, 17'(i), 9'h000);
      chk("free latch", 32'(rv), 32'h1ff);
    end
    foreach (rows[k]) begin
      go(rows[k].c, rows[k].a, rows[k].d);
      idle();
      chk("status", st, 32'(rows[k].own) << dpsem_host_pkg::ST_OWNED);
      if (rows[k].c == dpsem_host_pkg::CMD_SEM_READ || rows[k].c == dpsem_host_pkg::CMD_MEM_READ) begin
        rr(dpsem_host_pkg::REG_RDATA);
        chk("rdata", q, 32'(rows[k].rd));
      end
      racc(rows[k].s, 1'b0, rows[k].a, 9'h000);
      chk("right view", 32'(rv), 32'(rows[k].rq));
    end
    // Held by the right port: host keeps polling, then takes over
    racc(1'b1, 1'b1, 17'h00002, 9'h1fe);
    go(dpsem_host_pkg::CMD_SEM_CLAIM, 17'h00002, 9'h000);
    repeat (40) @(posedge ref_clk);
    rr(dpsem_host_pkg::REG_STATUS);
    chk("polling", q, 32'h9);
    racc(1'b1, 1'b1, 17'h00002, 9'h001);
    idle();
    chk("taken over", st, 32'h2);
    racc(1'b1, 1'b1, 17'h00002, 9'h000);
    go(dpsem_host_pkg::CMD_SEM_READ, 17'h00002, 9'h000);
    idle();
    rr(dpsem_host_pkg::REG_RDATA);
    chk("still held", q, 32'h0);
    go(dpsem_host_pkg::CMD_SEM_RELEASE, 17'h00002, 9'h001);
    idle();
    racc(1'b1, 1'b0, 17'h00002, 9'h000);
    chk("handed over", 32'(rv), 32'h0);
    racc(1'b1, 1'b1, 17'h00002, 9'h001);
    // Both ports claim one latch at once
    fork
      go(dpsem_host_pkg::CMD_SEM_CLAIM, 17'h00004, 9'h000);
      begin
        repeat (8) @(posedge ref_clk);
        racc(1'b1, 1'b1, 17'h00004, 9'h000);
      end
    join
    repeat (30) @(posedge ref_clk);
    rr(dpsem_host_pkg::REG_STATUS);
    racc(1'b1, 1'b0, 17'h00004, 9'h000);
    chk("one winner", 32'(q[dpsem_host_pkg::ST_OWNED] ^ (rv == 9'h000)), 32'h1);
    racc(1'b1, 1'b1, 17'h00004, 9'h001);
    idle();
    go(dpsem_host_pkg::CMD_SEM_RELEASE, 17'h00004, 9'h001);
    idle();
    // Mailboxes
    racc(1'b0, 1'b1, dpsem_host_pkg::LEFT_MBOX_ADDR, 9'h0c3);
    repeat (4) @(posedge ref_clk);
    rr(dpsem_host_pkg::REG_STATUS);
    chk("own flag set", q, 32'h4);
    go(dpsem_host_pkg::CMD_MEM_WRITE, dpsem_host_pkg::RIGHT_MBOX_ADDR, 9'h13c);
    idle();
    go(dpsem_host_pkg::CMD_MEM_READ, dpsem_host_pkg::RIGHT_MBOX_ADDR, 9'h000);
    idle();
    rr(dpsem_host_pkg::REG_RDATA);
    chk("peer word", q, 32'h13c);
    chk("peer flag", 32'(irq_n[1]), 32'h0);
    racc(1'b0, 1'b0, dpsem_host_pkg::RIGHT_MBOX_ADDR, 9'h000);
    chk("peer flag clear", 32'({rv, irq_n[1]}), {22'h0, 9'h13c, 1'b1});
    go(dpsem_host_pkg::CMD_MEM_READ, dpsem_host_pkg::LEFT_MBOX_ADDR, 9'h000);
    idle();
    rr(dpsem_host_pkg::REG_RDATA);
    chk("own word", q, 32'h0c3);
    repeat (4) @(posedge ref_clk);
    rr(dpsem_host_pkg::REG_STATUS);
    chk("own flag clear", q, 32'h0);
    // Command while busy and unknown code are ignored
    go(dpsem_host_pkg::CMD_MEM_WRITE, 17'h00040, 9'h011);
    rw(dpsem_host_pkg::REG_CMD, 32'(dpsem_host_pkg::CMD_SEM_CLAIM));
    idle();
    rw(dpsem_host_pkg::REG_CMD, 32'h7);
    rr(dpsem_host_pkg::REG_STATUS);
    chk("refused status", q, 32'h0);
    chk("refused idle", st, 32'h0);
    racc(1'b1, 1'b0, 17'h00040, 9'h000);
    chk("latch untouched", 32'(rv), 32'h1ff);
    // Reset in mid-run clears host state but not the device
    go(dpsem_host_pkg::CMD_SEM_CLAIM, 17'h00006, 9'h000);
    idle();
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rr(dpsem_host_pkg::REG_STATUS);
    chk("after reset", q, 32'h0);
    go(dpsem_host_pkg::CMD_SEM_CLAIM, 17'h00006, 9'h000);
    idle();
    chk("reclaim", st, 32'h2);
    end_sim();
  end
endmodule // tb
`default_nettype wire
